// ===== verilog/spi_sb_device.sv
// spi device end: status flags, double-buffered data register, pins
// assumes register port and pins as below; pin inputs are asynchronous
//
// The register offsets and the APB slave port were decided locally.
module spi_sb_device
  import spi_sb_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
)
(
  input wire logic clock,
  input wire logic sys_rst,
  spi_reg_if.dev bus,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in,
  output logic ss_n_out,
  output logic ss_n_oe
);
  // synchroniser lane order
  localparam int P_MISO = 0;
  localparam int P_MOSI = 1;
  localparam int P_SCLK = 2;
  localparam int P_SS = 3;

  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic [7:0] rdata;
    logic tx_full;
    logic rx_full;
    logic mode_fault_flag;
    logic arm_rf;
    logic arm_te;
    logic arm_mf;
    logic ack;
    logic irq;
    logic [3:0] s1;
    logic [3:0] s2;
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_o;
    logic ss_oe;
  } dev_t;

  dev_t dev_reg;
  dev_t dev_next;
  logic eng_busy;
  logic eng_done;
  logic [7:0] eng_rx;
  logic eng_sclk;
  logic eng_sdo;
  logic master;
  logic tx_empty;
  logic load;
  logic fault;
  logic [7:0] status;

  // ------------------------------------------------------------------
  // shift engine
  // ------------------------------------------------------------------
  spi_shift_engine #(
    .HALF_CYC(HALF_CYC)
  ) u_eng (
    .clock(clock),
    .sys_rst(sys_rst),
    .master(master),
    .load(load),
    .load_data(dev_reg.tx_buf),
    .sclk_s(dev_reg.s2[P_SCLK]),
    .sel(~dev_reg.s2[P_SS]),
    .sdi(master ? dev_reg.s2[P_MISO] : dev_reg.s2[P_MOSI]),
    .busy(eng_busy),
    .done(eng_done),
    .rx_data(eng_rx),
    .sclk_o(eng_sclk),
    .sdo(eng_sdo)
  );

  // ------------------------------------------------------------------
  // flag terms
  // ------------------------------------------------------------------
  always_comb
  begin
    master = dev_reg.c1[C1_MASTER_BIT];
    tx_empty = ~dev_reg.tx_full;
    // slave only takes a byte between frames
    load = dev_reg.tx_full && !eng_busy
      && (master || dev_reg.s2[P_SS]);
    fault = master && dev_reg.c2[C2_FAULT_EN_BIT]
      && !dev_reg.c1[C1_SEL_OUT_EN_BIT] && !dev_reg.s2[P_SS];
    status = 8'h00;
    status[ST_RX_FULL_BIT] = dev_reg.rx_full;
    status[ST_TX_EMPTY_BIT] = tx_empty;
    status[ST_MODE_FAULT_BIT] = dev_reg.mode_fault_flag;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    dev_next = dev_reg;
    dev_next.ack = 1'b0;
    dev_next.s1 = {ss_n_in, sclk_in, mosi_in, miso_in};
    dev_next.s2 = dev_reg.s1;
    if (load)
      dev_next.tx_full = 1'b0;
    // register access, answered one cycle later
    if (bus.req)
    begin
      dev_next.ack = 1'b1;
      case (bus.addr)
        REG_STATUS:
        begin
          if (!bus.wr)
          begin
            // read arms the clear sequence of each flag that is set; writes dropped
            dev_next.rdata = status;
            dev_next.arm_rf = dev_reg.rx_full;
            dev_next.arm_te = tx_empty;
            dev_next.arm_mf = dev_reg.mode_fault_flag;
          end
        end
        REG_DATA:
        begin
          if (bus.wr)
          begin
            if (dev_reg.arm_te && tx_empty)
            begin
              dev_next.tx_buf = bus.wdata;
              dev_next.tx_full = 1'b1;
              dev_next.arm_te = 1'b0;
            end
          end
          else
          begin
            dev_next.rdata = dev_reg.rx_buf;
            if (dev_reg.arm_rf && dev_reg.rx_full)
            begin
              dev_next.rx_full = 1'b0;
              dev_next.arm_rf = 1'b0;
            end
          end
        end
        REG_CTRL1:
        begin
          if (bus.wr)
          begin
            dev_next.c1 = bus.wdata;
            if (dev_reg.arm_mf && dev_reg.mode_fault_flag)
            begin
              dev_next.mode_fault_flag = 1'b0;
              dev_next.arm_mf = 1'b0;
            end
          end
          else
            dev_next.rdata = dev_reg.c1;
        end
        REG_CTRL2:
        begin
          if (bus.wr)
            dev_next.c2 = bus.wdata;
          else
            dev_next.rdata = dev_reg.c2;
        end
        default:
          dev_next.rdata = 8'h00;
      endcase
    end
    // transfer end: old unread byte wins, set beats clear
    if (eng_done && !dev_next.rx_full)
    begin
      dev_next.rx_buf = eng_rx;
      dev_next.rx_full = 1'b1;
    end
    if (fault)
      dev_next.mode_fault_flag = 1'b1;
    dev_next.irq = !dev_next.tx_full
      && dev_next.c1[C1_TX_IRQ_EN_BIT];
    // registered pin drivers
    dev_next.sclk_o = eng_sclk;
    dev_next.sclk_oe = master;
    dev_next.mosi_o = eng_sdo;
    dev_next.mosi_oe = master;
    dev_next.miso_o = eng_sdo;
    dev_next.miso_oe = !master && !dev_reg.s2[P_SS];
    dev_next.ss_o = !eng_busy;
    dev_next.ss_oe = master && dev_reg.c2[C2_FAULT_EN_BIT]
      && dev_reg.c1[C1_SEL_OUT_EN_BIT];
  end

  // reset: both buffers empty, only transmit-empty shows
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dev_reg <= '0;
      dev_reg.c1 <= CTRL1_RESET;
      dev_reg.c2 <= CTRL2_RESET;
      dev_reg.tx_buf <= DATA_RESET;
      dev_reg.rx_buf <= DATA_RESET;
      // idle levels, so no false clock edge follows reset
      dev_reg.s1 <= PIN_SYNC_RESET;
      dev_reg.s2 <= PIN_SYNC_RESET;
      dev_reg.ss_o <= 1'b1;
    end
    else
      dev_reg <= dev_next;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign bus.rdata = dev_reg.rdata;
  assign bus.ack = dev_reg.ack;
  assign bus.irq = dev_reg.irq;
  assign sclk_out = dev_reg.sclk_o;
  assign sclk_oe = dev_reg.sclk_oe;
  assign mosi_out = dev_reg.mosi_o;
  assign mosi_oe = dev_reg.mosi_oe;
  assign miso_out = dev_reg.miso_o;
  assign miso_oe = dev_reg.miso_oe;
  assign ss_n_out = dev_reg.ss_o;
  assign ss_n_oe = dev_reg.ss_oe;
endmodule

// ===== include/spi_sb_pkg.sv
// constants shared by the spi status/data-buffer device and its controller
// assumes one 250 MHz clock and an apb master in front of the controller
package spi_sb_pkg;
  // ------------------------------------------------------------------
  // device register port
  // ------------------------------------------------------------------
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_DATA = 2'h1;
  localparam logic [1:0] REG_CTRL1 = 2'h2;
  localparam logic [1:0] REG_CTRL2 = 2'h3;
  localparam int ST_RX_FULL_BIT = 7;
  localparam int ST_TX_EMPTY_BIT = 5;
  localparam int ST_MODE_FAULT_BIT = 4;
  localparam int C1_TX_IRQ_EN_BIT = 5;
  localparam int C1_MASTER_BIT = 4;
  localparam int C1_SEL_OUT_EN_BIT = 1;
  localparam int C2_FAULT_EN_BIT = 4;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // synchroniser lanes {select, clock, mosi, miso} at idle pin levels
  localparam logic [3:0] PIN_SYNC_RESET = 4'hb;
  // ------------------------------------------------------------------
  // controller apb map
  // ------------------------------------------------------------------
  localparam logic [7:0] ORDER_OFS = 8'h00;
  localparam logic [7:0] RESULT_OFS = 8'h04;
  localparam int ORDER_ADDR_LSB = 8;
  localparam int ORDER_WRITE_BIT = 10;
  localparam int RESULT_BUSY_BIT = 8;
  localparam int RESULT_IRQ_BIT = 9;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_HALF_NS = 8;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int TX_RELOAD_CYC = 2;
endpackage

// ===== include/spi_reg_if.sv
// register port between the spi device and its controller
// assumes both ends run on the same clock
interface spi_reg_if;
  logic req;
  logic wr;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic irq;
  modport dev
  (
    input req, wr, addr, wdata,
    output rdata, ack, irq
  );
  modport ctl
  (
    output req, wr, addr, wdata,
    input rdata, ack, irq
  );
endinterface

// ===== verilog/spi_shift_engine.sv
// eight-bit shift engine, clock format cpol 0 / cpha 0, msb first
// assumes pin inputs are already synchronised by the caller
module spi_shift_engine
  import spi_sb_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic master,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic sclk_s,
  input wire logic sel,
  input wire logic sdi,
  output logic busy,
  output logic done,
  output logic [7:0] rx_data,
  output logic sclk_o,
  output logic sdo
);
  // refuse divisions that the eight-bit divider cannot count
  if (HALF_CYC < 1 || HALF_CYC > 256)
  begin : g_bad_half
    $error("HALF_CYC out of range");
  end

  typedef struct packed {
    logic [7:0] sh;
    logic smp;
    logic [2:0] cnt;
    logic [7:0] div;
    logic sclk;
    logic sclk_prev;
    logic busy;
    logic done;
    logic [7:0] rx;
  } eng_t;

  eng_t eng_reg;
  eng_t eng_next;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    eng_next = eng_reg;
    eng_next.done = 1'b0;
    eng_next.sclk_prev = sclk_s;
    if (load)
    begin
      eng_next.sh = load_data;
      eng_next.busy = 1'b1;
      eng_next.cnt = 3'h0;
      eng_next.div = 8'h00;
      eng_next.sclk = 1'b0;
    end
    else if (master && eng_reg.busy)
    begin
      // master: own bit clock from the divider
      if (eng_reg.div == 8'(HALF_CYC - 1))
      begin
        eng_next.div = 8'h00;
        eng_next.sclk = ~eng_reg.sclk;
        if (!eng_reg.sclk)
          eng_next.smp = sdi;
        else if (eng_reg.cnt == 3'h7)
        begin
          eng_next.done = 1'b1;
          eng_next.busy = 1'b0;
          eng_next.rx = {eng_reg.sh[6:0], eng_reg.smp};
        end
        else
        begin
          eng_next.cnt = eng_reg.cnt + 3'h1;
          eng_next.sh = {eng_reg.sh[6:0], eng_reg.smp};
        end
      end
      else
        eng_next.div = eng_reg.div + 8'h01;
    end
    else if (!master)
    begin
      // slave: follow the far clock while selected
      if (!sel)
        eng_next.cnt = 3'h0;
      else if (sclk_s && !eng_reg.sclk_prev)
      begin
        if (eng_reg.cnt == 3'h7)
        begin
          eng_next.done = 1'b1;
          eng_next.busy = 1'b0;
          eng_next.cnt = 3'h0;
          eng_next.rx = {eng_reg.sh[6:0], sdi};
        end
        else
        begin
          eng_next.cnt = eng_reg.cnt + 3'h1;
          eng_next.smp = sdi;
        end
      end
      else if (!sclk_s && eng_reg.sclk_prev && eng_reg.cnt != 3'h0)
        eng_next.sh = {eng_reg.sh[6:0], eng_reg.smp};
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      eng_reg <= '0;
    else
      eng_reg <= eng_next;
  end

  assign busy = eng_reg.busy;
  assign done = eng_reg.done;
  assign rx_data = eng_reg.rx;
  assign sclk_o = eng_reg.sclk;
  assign sdo = eng_reg.sh[7];
endmodule

// ===== verilog/spi_reg_ctrl.sv
// controller end: apb slave that turns orders into register accesses
// assumes an apb master on the same clock as the device
module spi_reg_ctrl
  import spi_sb_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  spi_reg_if.ctl bus
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} ctl_state_t;

  typedef struct packed {
    ctl_state_t state;
    logic req;
    logic wr;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic [7:0] result;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctl_t;

  ctl_t ctl_reg;
  ctl_t ctl_next;
  logic access;
  logic finish;
  logic order;

  // ------------------------------------------------------------------
  // apb and order sequencing
  // ------------------------------------------------------------------
  always_comb
  begin
    ctl_next = ctl_reg;
    ctl_next.req = 1'b0;
    ctl_next.pready = 1'b0;
    ctl_next.pslverr = 1'b0;
    access = psel && penable && !ctl_reg.pready;
    finish = psel && penable && ctl_reg.pready;
    order = pwrite && paddr == ORDER_OFS;
    if (access)
    begin
      // an order stalls until the previous one is answered
      if (!order || ctl_reg.state == ST_IDLE)
        ctl_next.pready = 1'b1;
      ctl_next.pslverr = !(order || (!pwrite && paddr == RESULT_OFS));
      ctl_next.prdata = 32'h0;
      if (!pwrite && paddr == RESULT_OFS)
      begin
        ctl_next.prdata[7:0] = ctl_reg.result;
        ctl_next.prdata[RESULT_BUSY_BIT] = ctl_reg.state != ST_IDLE;
        ctl_next.prdata[RESULT_IRQ_BIT] = bus.irq;
      end
    end
    case (ctl_reg.state)
      ST_IDLE:
      begin
        if (finish && order)
        begin
          ctl_next.req = 1'b1;
          ctl_next.wr = pwdata[ORDER_WRITE_BIT];
          ctl_next.addr = pwdata[ORDER_ADDR_LSB +: 2];
          ctl_next.wdata = pwdata[7:0];
          ctl_next.state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (bus.ack)
        begin
          ctl_next.result = bus.rdata;
          ctl_next.state = ST_IDLE;
        end
      end
      default:
        ctl_next.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      ctl_reg <= '0;
    else
      ctl_reg <= ctl_next;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign prdata = ctl_reg.prdata;
  assign pready = ctl_reg.pready;
  assign pslverr = ctl_reg.pslverr;
  assign bus.req = ctl_reg.req;
  assign bus.wr = ctl_reg.wr;
  assign bus.addr = ctl_reg.addr;
  assign bus.wdata = ctl_reg.wdata;
endmodule

// ===== verif/spi_sb_monitor.sv
// concurrent checks on the register port between controller and device
// assumes one clock; inputs come straight from the joining interface
module spi_sb_monitor
  import spi_sb_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic wr,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic armed_reg;
  logic wrote_reg;
  logic st_rd;
  logic irq_en;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // status read answered, transmit irq enable shadow
  assign st_rd = ack && !wr && addr == REG_STATUS;
  assign irq_en = ctrl1_reg[C1_TX_IRQ_EN_BIT];
  // shadow controls, fault arming and data writes
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl1_reg <= CTRL1_RESET;
      ctrl2_reg <= CTRL2_RESET;
      armed_reg <= 1'b0;
      wrote_reg <= 1'b0;
    end
    else
    begin
      if (req && wr && addr == REG_CTRL1)
        ctrl1_reg <= wdata;
      if (req && wr && addr == REG_CTRL2)
        ctrl2_reg <= wdata;
      if (req && wr && addr == REG_DATA)
        wrote_reg <= 1'b1;
      if (ctrl1_reg[C1_MASTER_BIT] && ctrl2_reg[C2_FAULT_EN_BIT]
        && !ctrl1_reg[C1_SEL_OUT_EN_BIT])
        armed_reg <= 1'b1;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  ack_timing_a: assert property (req |=> ack)
    else $error("access not answered one cycle later");
  stray_ack_a: assert property (!req |=> !ack)
    else $error("answer without request");
  rdata_hold_a: assert property (!(ack && !wr) |-> $stable(rdata))
    else $error("read data moved without a read");
  zero_bits_a: assert property (st_rd |-> (rdata & 8'h4f) == 8'h00)
    else $error("unused status bits not zero");
  irq_mask_a: assert property (!irq_en && !$past(irq_en) |-> !irq)
    else $error("irq while disabled");
  irq_match_a: assert property (
    st_rd && $past(irq_en) |-> $past(irq) == rdata[ST_TX_EMPTY_BIT])
    else $error("irq differs from transmit empty");
  fault_config_a: assert property (
    st_rd && rdata[ST_MODE_FAULT_BIT] |-> armed_reg)
    else $error("mode fault outside fault configuration");
  init_flags_a: assert property (
    st_rd && !wrote_reg |-> !rdata[ST_RX_FULL_BIT] && rdata[ST_TX_EMPTY_BIT])
    else $error("flags moved before any data write");
endmodule

// ===== verif/testbench.sv
// bench: apb orders drive the controller, which works the spi device
// assumes package, interface, both design ends and monitor compiled first
module testbench
  import spi_sb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ss_drive = 1'b1;
  logic sclk_drive = 1'b0;
  logic mosi_drive = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic ss_n_out, ss_n_oe;
  wire logic sclk_in, mosi_in, miso_in, ss_n_in;
  int fails = 0;
  int checked = 0;
  int seed = 87;
  int edges = 0;
  logic [15:0] shifted = 16'h0000;
  spi_reg_if rif ();
  // pin levels: bench acts as far master when pins are released
  assign sclk_in = sclk_oe ? sclk_out : sclk_drive;
  assign mosi_in = mosi_oe ? mosi_out : mosi_drive;
  assign miso_in = miso_oe ? miso_out : mosi_oe ? mosi_out : 1'b1;
  assign ss_n_in = ss_n_oe ? ss_n_out : ss_drive;
  // 250 mhz clock
  always #2 clock = ~clock;
  spi_sb_device #(.HALF_CYC(4)) i_spi_sb_device
  (
    .clock(clock), .sys_rst(sys_rst), .bus(rif),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe),
    .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe)
  );
  spi_reg_ctrl i_spi_reg_ctrl
  (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(rif)
  );
  spi_sb_monitor i_spi_sb_monitor
  (
    .clock(clock), .sys_rst(sys_rst), .req(rif.req), .wr(rif.wr),
    .addr(rif.addr), .wdata(rif.wdata), .rdata(rif.rdata),
    .ack(rif.ack), .irq(rif.irq)
  );
  // wire watcher: count clock rises, collect mosi msb first
  always @(posedge sclk_out)
  begin
    edges <= edges + 1;
    shifted <= {shifted[14:0], mosi_out};
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task check(input string what, input logic [31:0] seen,
    input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer, then one idle cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 200);
    if (pready !== 1'b1)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // device access: order, then poll result until not busy
  task dev(input logic w, input logic [1:0] a, input logic [7:0] d,
    output logic [31:0] r);
    logic e;
    int n;
    r = 32'h0;
    r[7:0] = d;
    r[ORDER_ADDR_LSB +: 2] = a;
    r[ORDER_WRITE_BIT] = w;
    apb(1'b1, ORDER_OFS, r, r, e);
    n = 0;
    do
    begin
      apb(1'b0, RESULT_OFS, 32'h0, r, e);
      n++;
    end
    while (r[RESULT_BUSY_BIT] !== 1'b0 && n < 50);
    if (r[RESULT_BUSY_BIT] !== 1'b0)
      fails++;
  endtask
  // wait until select stays high for eight cycles
  task wait_idle;
    int quiet;
    int k;
    quiet = 0;
    k = 0;
    while (quiet < 8 && k < 1000)
    begin
      @(posedge clock);
      quiet = ss_n_out ? quiet + 1 : 0;
      k++;
    end
    if (quiet < 8)
      fails++;
  endtask
  function automatic logic [7:0] st(logic rxf, logic txe, logic mf);
    return {rxf, 1'b0, txe, mf, 4'h0};
  endfunction
  // watchdog far beyond the longest expected run
  initial
  begin
    repeat (40000) @(posedge clock);
    fails++;
    stop_test;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic e;
    logic [7:0] a;
    logic [7:0] b;
    int i;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    dev(1'b0, REG_STATUS, 8'h00, r);
    check("reset status", r[7:0], st(1'b0, 1'b1, 1'b0));
    dev(1'b1, REG_STATUS, 8'hff, r);
    dev(1'b0, REG_STATUS, 8'h00, r);
    check("status write", r[7:0], st(1'b0, 1'b1, 1'b0));
    apb(1'b1, 8'h08, 32'h0, r, e);
    check("unmapped", e, 1'b1);
    // interrupt follows transmit empty while enabled
    dev(1'b1, REG_CTRL1, 8'h1 << C1_TX_IRQ_EN_BIT, r);
    dev(1'b0, REG_STATUS, 8'h00, r);
    check("irq on", r[RESULT_IRQ_BIT], 1'b1);
    dev(1'b1, REG_CTRL1, 8'h1 << C1_MASTER_BIT, r);
    check("irq off", r[RESULT_IRQ_BIT], 1'b0);
    // master loopback transfers, corner bytes first
    for (i = 0; i < 4; i++)
    begin
      a = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
      edges = 0;
      dev(1'b0, REG_STATUS, 8'h00, r);
      dev(1'b1, REG_DATA, a, r);
      dev(1'b0, REG_STATUS, 8'h00, r);
      check("tx reload", r[ST_TX_EMPTY_BIT], 1'b1);
      wait_idle;
      check("wire byte", shifted[7:0], a);
      check("wire edges", edges, 8);
      check("idle clock", sclk_out, 1'b0);
      dev(1'b0, REG_STATUS, 8'h00, r);
      check("rx full", r[7:0], st(1'b1, 1'b1, 1'b0));
      dev(1'b0, REG_DATA, 8'h00, r);
      check("rx data", r[7:0], a);
      dev(1'b0, REG_STATUS, 8'h00, r);
      check("rx clear", r[7:0], st(1'b0, 1'b1, 1'b0));
    end
    // queued byte, refused write, overrun keeps first byte
    a = 8'($random(seed));
    b = ~a;
    edges = 0;
    dev(1'b0, REG_STATUS, 8'h00, r);
    dev(1'b1, REG_DATA, a, r);
    dev(1'b0, REG_STATUS, 8'h00, r);
    dev(1'b1, REG_DATA, b, r);
    dev(1'b1, REG_DATA, 8'h5a, r);
    dev(1'b0, REG_STATUS, 8'h00, r);
    check("tx queued", r[ST_TX_EMPTY_BIT], 1'b0);
    wait_idle;
    check("wire bytes", shifted, {a, b});
    check("wire edges", edges, 16);
    dev(1'b0, REG_STATUS, 8'h00, r);
    check("two done", r[7:0], st(1'b1, 1'b1, 1'b0));
    dev(1'b0, REG_DATA, 8'h00, r);
    check("overrun", r[7:0], a);
    // every select configuration against a low select pin
    for (i = 7; i >= 0; i--)
    begin
      dev(1'b1, REG_CTRL2, 8'(i[1]) << C2_FAULT_EN_BIT, r);
      dev(1'b1, REG_CTRL1, 8'(i[0]) << C1_MASTER_BIT
        | 8'(i[2]) << C1_SEL_OUT_EN_BIT, r);
      ss_drive <= 1'b0;
      dev(1'b0, REG_STATUS, 8'h00, r);
      check("fault", r[7:0], st(1'b0, 1'b1, i == 3));
      check("select out", ss_n_oe, i == 7);
      ss_drive <= 1'b1;
      dev(1'b1, REG_CTRL1, 8'h00, r);
      dev(1'b0, REG_STATUS, 8'h00, r);
      check("fault clear", r[7:0], st(1'b0, 1'b1, 1'b0));
    end
    // slave receive: bench clocks one byte in, msb first
    a = 8'($random(seed));
    ss_drive <= 1'b0;
    repeat (4) @(posedge clock);
    for (i = 7; i >= 0; i--)
    begin
      mosi_drive <= a[i];
      repeat (4) @(posedge clock);
      sclk_drive <= 1'b1;
      repeat (4) @(posedge clock);
      sclk_drive <= 1'b0;
    end
    repeat (4) @(posedge clock);
    ss_drive <= 1'b1;
    dev(1'b0, REG_STATUS, 8'h00, r);
    check("slave full", r[7:0], st(1'b1, 1'b1, 1'b0));
    dev(1'b0, REG_DATA, 8'h00, r);
    check("slave data", r[7:0], a);
    stop_test;
  end
endmodule
